// ---- src/udsc_char_match.sv ----
/*
  udsc_char_match: compares one character against the pause and resume
  characters of the pairs that a flow mode selects.
  assumes all inputs come from logic on the same clock; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module udsc_char_match (
  input  wire logic [1:0] mode,
  input  wire logic [7:0] resume1,
  input  wire logic [7:0] resume2,
  input  wire logic [7:0] pause1,
  input  wire logic [7:0] pause2,
  input  wire logic [7:0] ch,
  output logic            isPause,
  output logic            isResume
);
  import udsc_pkg::*;

  logic usePair1;
  logic usePair2;

  // ----------------------------------------
  // pair selection and compare
  // ----------------------------------------
  always_comb begin
    usePair1 = (mode == FLOW_PAIR1) || (mode == FLOW_BOTH);
    usePair2 = (mode == FLOW_PAIR2) || (mode == FLOW_BOTH);
    isPause  = (usePair1 && (ch == pause1)) || (usePair2 && (ch == pause2));
    isResume = (usePair1 && (ch == resume1)) || (usePair2 && (ch == resume2));
  end

endmodule : udsc_char_match
`default_nettype wire

// ---- src/udsc_dma_req.sv ----
/*
  udsc_dma_req: registered receive and transmit dma request lines.
  assumes fifo levels, error interrupt and halt come from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module udsc_dma_req (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire udsc_pkg::udsc_dma_ctrl_t dmaCtrl,
  input  wire logic                    rxDataAvail,
  input  wire logic                    txSpaceAvail,
  input  wire logic                    uartErrIrq,
  input  wire logic                    txHalt,
  output logic                         rxDmaReq,
  output logic                         txDmaReq
);
  import udsc_pkg::*;

  udsc_dma_state_t s_q;
  udsc_dma_state_t s_d;

  // ----------------------------------------
  // request gating
  // ----------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.rxReq = dmaCtrl.rxDmaEnable && rxDataAvail
                && !(dmaCtrl.dmaBlockOnError && uartErrIrq);
    s_d.txReq = dmaCtrl.txDmaEnable && txSpaceAvail && !txHalt;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_q <= DMA_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rxDmaReq = s_q.rxReq;
  assign txDmaReq = s_q.txReq;

endmodule : udsc_dma_req
`default_nettype wire

// ---- src/udsc_pkg.sv ----
/*
  udsc_pkg: register map, field layout, reset values and carrier types of
  the uart dma and software flow control block.
  assumes a 32-bit axi4-lite bus with 8 address bits reaching this block.
*/
`default_nettype none
package udsc_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_DMA_CTRL  = 8'h48;
  localparam logic [7:0] ADDR_FLOW_CFG  = 8'h50;
  localparam logic [7:0] ADDR_RESUME1   = 8'h54;
  localparam logic [7:0] ADDR_RESUME2   = 8'h58;
  localparam logic [7:0] ADDR_PAUSE1    = 8'h5C;
  localparam logic [7:0] ADDR_PAUSE2    = 8'h60;
  localparam logic [7:0] ADDR_FLOW_STAT = 8'h64;

  // ----------------------------------------
  // register select codes
  // ----------------------------------------
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_DMA  = 3'h1;
  localparam logic [2:0] SEL_FLOW = 3'h2;
  localparam logic [2:0] SEL_RES1 = 3'h3;
  localparam logic [2:0] SEL_RES2 = 3'h4;
  localparam logic [2:0] SEL_PAU1 = 3'h5;
  localparam logic [2:0] SEL_PAU2 = 3'h6;
  localparam logic [2:0] SEL_STAT = 3'h7;

  // ----------------------------------------
  // field positions and codes
  // ----------------------------------------
  localparam int DMA_CTRL_W   = 4;
  localparam int FLOW_CFG_W   = 7;
  localparam int CHAR_W       = 8;
  localparam int ST_TX_HALT   = 0;
  localparam int ST_SPEC      = 1;
  localparam int ST_RX_PAUSED = 2;
  localparam logic [1:0] FLOW_OFF   = 2'h0;
  localparam logic [1:0] FLOW_PAIR1 = 2'h1;
  localparam logic [1:0] FLOW_PAIR2 = 2'h2;
  localparam logic [1:0] FLOW_BOTH  = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic       dmaBlockOnError;
    logic       rsvd;
    logic       txDmaEnable;
    logic       rxDmaEnable;
  } udsc_dma_ctrl_t;

  typedef struct packed {
    logic       specialCharDetect;
    logic       resumeOnAnyChar;
    logic [1:0] txFlowMode;
    logic [1:0] rxFlowMode;
    logic       swFlowEnable;
  } udsc_flow_cfg_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } udsc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } udsc_axi_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } udsc_char_t;

  typedef enum logic [2:0] {
    SND_IDLE   = 3'b001,
    SND_FIRST  = 3'b010,
    SND_SECOND = 3'b100
  } udsc_snd_state_t;

  typedef struct packed {
    udsc_axi_rsp_t   rsp;
    logic            awHeld;
    logic [7:0]      awAddr;
    logic            wHeld;
    logic [31:0]     wData;
    logic [3:0]      wStrb;
    udsc_dma_ctrl_t  dmaCtrl;
    udsc_flow_cfg_t  flowCfg;
    logic [7:0]      resume1;
    logic [7:0]      resume2;
    logic [7:0]      pause1;
    logic [7:0]      pause2;
    logic            txHalt;
    logic            specSticky;
    logic            specPulse;
    logic            rxPausedSent;
    logic            sndPause;
    udsc_snd_state_t sndState;
    udsc_char_t      ins;
  } udsc_top_state_t;

  typedef struct packed {
    logic rxReq;
    logic txReq;
  } udsc_dma_state_t;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam udsc_top_state_t TOP_STATE_RST = '{
    rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
    sndState: SND_IDLE,
    default: '0
  };
  localparam udsc_dma_state_t DMA_STATE_RST = '{default: '0};

endpackage : udsc_pkg
`default_nettype wire

// ---- src/udsc_top.sv ----
/*
  udsc_top: axi4-lite register slave, dma request gating and in-band
  software flow control of a uart.
  assumes the receiver hands over characters as one-cycle strobes, the
  transmitter takes inserted flow characters by a valid/ack handshake and
  honours the halt line; everything runs on ref_clk.
*/
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module udsc_top (
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  wire udsc_pkg::udsc_axi_req_t axiReq,
  output udsc_pkg::udsc_axi_rsp_t      axiRsp,
  input  wire udsc_pkg::udsc_char_t    rxChar,
  input  wire logic                   rxAlmostFull,
  input  wire logic                   rxDataAvail,
  input  wire logic                   txSpaceAvail,
  input  wire logic                   uartErrIrq,
  input  wire logic                   txInsertAck,
  output udsc_pkg::udsc_char_t         txInsert,
  output logic                        txHalt,
  output logic                        specialCharSeen,
  output logic                        rxDmaReq,
  output logic                        txDmaReq
);
  import udsc_pkg::*;

  udsc_top_state_t s_q;
  udsc_top_state_t s_d;

  logic txIsPause;
  logic txIsResume;
  logic anyIsPause;
  logic anyIsResume;
  logic flowOn;
  logic wantPause;
  logic wrSpecClr;
  logic [2:0] wrSel;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic [2:0] regSel(input logic [7:0] addr);
    logic [7:0] a;
    a = {addr[7:2], 2'b00};
    unique case (a)
      ADDR_DMA_CTRL:  regSel = SEL_DMA;
      ADDR_FLOW_CFG:  regSel = SEL_FLOW;
      ADDR_RESUME1:   regSel = SEL_RES1;
      ADDR_RESUME2:   regSel = SEL_RES2;
      ADDR_PAUSE1:    regSel = SEL_PAU1;
      ADDR_PAUSE2:    regSel = SEL_PAU2;
      ADDR_FLOW_STAT: regSel = SEL_STAT;
      default:        regSel = SEL_NONE;
    endcase
  endfunction : regSel

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  function automatic logic [31:0] readReg(
    input logic [2:0]      sel,
    input udsc_top_state_t s
  );
    readReg = 32'h0000_0000;
    unique case (sel)
      SEL_DMA: begin
        readReg[DMA_CTRL_W-1:0] = s.dmaCtrl;
      end
      SEL_FLOW: begin
        readReg[FLOW_CFG_W-1:0] = s.flowCfg;
      end
      SEL_RES1: begin
        readReg[CHAR_W-1:0] = s.resume1;
      end
      SEL_RES2: begin
        readReg[CHAR_W-1:0] = s.resume2;
      end
      SEL_PAU1: begin
        readReg[CHAR_W-1:0] = s.pause1;
      end
      SEL_PAU2: begin
        readReg[CHAR_W-1:0] = s.pause2;
      end
      SEL_STAT: begin
        readReg[ST_TX_HALT]   = s.txHalt;
        readReg[ST_SPEC]      = s.specSticky;
        readReg[ST_RX_PAUSED] = s.rxPausedSent;
      end
      default: begin
        readReg = 32'h0000_0000;
      end
    endcase
  endfunction : readReg

  // ----------------------------------------
  // flow character pick for sending
  // ----------------------------------------
  function automatic logic [7:0] flowChar(
    input logic            pause,
    input logic            second,
    input udsc_top_state_t s
  );
    if (pause) begin
      flowChar = second ? s.pause2 : s.pause1;
    end else begin
      flowChar = second ? s.resume2 : s.resume1;
    end
  endfunction : flowChar

  // ----------------------------------------
  // character compare
  // ----------------------------------------
  udsc_char_match uTxMatch (
    .mode     (s_q.flowCfg.txFlowMode),
    .resume1  (s_q.resume1),
    .resume2  (s_q.resume2),
    .pause1   (s_q.pause1),
    .pause2   (s_q.pause2),
    .ch       (rxChar.data),
    .isPause  (txIsPause),
    .isResume (txIsResume)
  );

  udsc_char_match uSpecMatch (
    .mode     (FLOW_BOTH),
    .resume1  (s_q.resume1),
    .resume2  (s_q.resume2),
    .pause1   (s_q.pause1),
    .pause2   (s_q.pause2),
    .ch       (rxChar.data),
    .isPause  (anyIsPause),
    .isResume (anyIsResume)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.specPulse = 1'b0;
    wrSpecClr     = 1'b0;
    wrSel         = regSel(s_q.awAddr);
    flowOn        = s_q.flowCfg.swFlowEnable;

    // write address and data, either order
    if (axiReq.awvalid && s_q.rsp.awready) begin
      s_d.awHeld      = 1'b1;
      s_d.awAddr      = axiReq.awaddr;
      s_d.rsp.awready = 1'b0;
    end
    if (axiReq.wvalid && s_q.rsp.wready) begin
      s_d.wHeld      = 1'b1;
      s_d.wData      = axiReq.wdata;
      s_d.wStrb      = axiReq.wstrb;
      s_d.rsp.wready = 1'b0;
    end

    // register write once both halves are held
    if (s_q.awHeld && s_q.wHeld && !s_q.rsp.bvalid) begin
      s_d.awHeld     = 1'b0;
      s_d.wHeld      = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (s_q.wStrb[0]) begin
        unique case (wrSel)
          SEL_DMA: begin
            s_d.dmaCtrl      = s_q.wData[DMA_CTRL_W-1:0];
            s_d.dmaCtrl.rsvd = 1'b0;
          end
          SEL_FLOW: begin
            s_d.flowCfg = s_q.wData[FLOW_CFG_W-1:0];
          end
          SEL_RES1: begin
            s_d.resume1 = s_q.wData[CHAR_W-1:0];
          end
          SEL_RES2: begin
            s_d.resume2 = s_q.wData[CHAR_W-1:0];
          end
          SEL_PAU1: begin
            s_d.pause1 = s_q.wData[CHAR_W-1:0];
          end
          SEL_PAU2: begin
            s_d.pause2 = s_q.wData[CHAR_W-1:0];
          end
          SEL_STAT: begin
            wrSpecClr = s_q.wData[ST_SPEC];
          end
          default: begin
            wrSpecClr = 1'b0;
          end
        endcase
      end
    end

    // write response
    if (s_q.rsp.bvalid && axiReq.bready) begin
      s_d.rsp.bvalid  = 1'b0;
      s_d.rsp.bresp   = RESP_OKAY;
      s_d.rsp.awready = 1'b1;
      s_d.rsp.wready  = 1'b1;
    end

    // read channel
    if (axiReq.arvalid && s_q.rsp.arready) begin
      s_d.rsp.arready = 1'b0;
      s_d.rsp.rvalid  = 1'b1;
      s_d.rsp.rdata   = readReg(regSel(axiReq.araddr), s_q);
      s_d.rsp.rresp   = (regSel(axiReq.araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (s_q.rsp.rvalid && axiReq.rready) begin
      s_d.rsp.rvalid  = 1'b0;
      s_d.rsp.rdata   = 32'h0000_0000;
      s_d.rsp.rresp   = RESP_OKAY;
      s_d.rsp.arready = 1'b1;
    end

    // special character detection, set wins over clear
    if (wrSpecClr) begin
      s_d.specSticky = 1'b0;
    end
    if (s_q.flowCfg.specialCharDetect && rxChar.valid
        && (anyIsPause || anyIsResume)) begin
      s_d.specSticky = 1'b1;
      s_d.specPulse  = 1'b1;
    end

    // transmit halt on received pause, release on resume
    if (!flowOn || (s_q.flowCfg.txFlowMode == FLOW_OFF)) begin
      s_d.txHalt = 1'b0;
    end else if (rxChar.valid) begin
      if (!s_q.txHalt && txIsPause) begin
        s_d.txHalt = 1'b1;
      end else if (s_q.txHalt
                   && (txIsResume || s_q.flowCfg.resumeOnAnyChar)) begin
        s_d.txHalt = 1'b0;
      end
    end

    // receive side: send pause or resume characters
    wantPause = flowOn && (s_q.flowCfg.rxFlowMode != FLOW_OFF)
                && rxAlmostFull;
    unique case (s_q.sndState)
      SND_IDLE: begin
        if (wantPause != s_q.rxPausedSent) begin
          s_d.sndPause   = wantPause;
          s_d.ins.valid  = 1'b1;
          s_d.ins.data   = flowChar(wantPause,
                                    s_q.flowCfg.rxFlowMode == FLOW_PAIR2, s_q);
          s_d.sndState   = SND_FIRST;
        end
      end
      SND_FIRST: begin
        if (txInsertAck) begin
          if (s_q.flowCfg.rxFlowMode == FLOW_BOTH) begin
            s_d.ins.data = flowChar(s_q.sndPause, 1'b1, s_q);
            s_d.sndState = SND_SECOND;
          end else begin
            s_d.ins.valid    = 1'b0;
            s_d.rxPausedSent = s_q.sndPause;
            s_d.sndState     = SND_IDLE;
          end
        end
      end
      SND_SECOND: begin
        if (txInsertAck) begin
          s_d.ins.valid    = 1'b0;
          s_d.rxPausedSent = s_q.sndPause;
          s_d.sndState     = SND_IDLE;
        end
      end
      default: begin
        s_d.ins.valid = 1'b0;
        s_d.sndState  = SND_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_q <= TOP_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // dma requests
  // ----------------------------------------
  udsc_dma_req uDma (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .dmaCtrl      (s_q.dmaCtrl),
    .rxDataAvail  (rxDataAvail),
    .txSpaceAvail (txSpaceAvail),
    .uartErrIrq   (uartErrIrq),
    .txHalt       (s_q.txHalt),
    .rxDmaReq     (rxDmaReq),
    .txDmaReq     (txDmaReq)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign axiRsp          = s_q.rsp;
  assign txInsert        = s_q.ins;
  assign txHalt          = s_q.txHalt;
  assign specialCharSeen = s_q.specPulse;

endmodule : udsc_top
`default_nettype wire

// ---- testbench/testbench.sv ----
/*
  testbench: axi4-lite master, dma and flow char scenarios for udsc_top.
  assumes udsc_pkg, udsc_top and udsc_far_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import udsc_pkg::*;
  logic ref_clk, resetn, rxAlmostFull, rxDataAvail, txSpaceAvail, uartErrIrq, txInsertAck;
  logic txHalt, specialCharSeen, rxDmaReq, txDmaReq;
  logic [3:0] slow;
  logic [15:0] sentLog;
  udsc_axi_req_t axiReq;
  udsc_axi_rsp_t axiRsp;
  udsc_char_t rxChar, txInsert;
  int bad_count, comparisons;
  localparam logic [7:0] ADRS [6] = '{ADDR_DMA_CTRL, ADDR_FLOW_CFG, ADDR_RESUME1, ADDR_RESUME2,
    ADDR_PAUSE1, ADDR_PAUSE2};
  localparam logic [31:0] MASK [6] = '{32'hB, 32'h7F, 32'hFF, 32'hFF, 32'hFF, 32'hFF};
  localparam logic [31:0] PROG [6] = '{32'h0, 32'h0, 32'h11, 32'h91, 32'h13, 32'h93};
  localparam logic [15:0] LOG_P [4] = '{16'h1191, 16'h0013, 16'h1193, 16'h1393};
  localparam logic [15:0] LOG_R [4] = '{16'h1191, 16'h1311, 16'h9391, 16'h1191};
  udsc_top dut_u (.ref_clk(ref_clk), .resetn(resetn), .axiReq(axiReq), .axiRsp(axiRsp), .rxChar(rxChar),
    .rxAlmostFull(rxAlmostFull), .rxDataAvail(rxDataAvail), .txSpaceAvail(txSpaceAvail),
    .uartErrIrq(uartErrIrq), .txInsertAck(txInsertAck), .txInsert(txInsert), .txHalt(txHalt),
    .specialCharSeen(specialCharSeen), .rxDmaReq(rxDmaReq), .txDmaReq(txDmaReq));
  udsc_far_model far_u (.ref_clk(ref_clk), .resetn(resetn), .txInsert(txInsert), .slow(slow),
    .txInsertAck(txInsertAck), .sentLog(sentLog));
  always #20 ref_clk = ~ref_clk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, ta, tw, got;
    @(posedge ref_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= a;
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= d;
    axiReq.wstrb   <= 4'hF;
    axiReq.bready  <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    got = 1'b0;
    while (aw || w) begin
      @(negedge ref_clk);
      ta = axiRsp.awready;
      tw = axiRsp.wready;
      @(posedge ref_clk);
      if (aw && ta) begin
        axiReq.awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && tw) begin
        axiReq.wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    while (!got) begin
      @(negedge ref_clk);
      got = axiRsp.bvalid;
      r = axiRsp.bresp;
    end
    @(posedge ref_clk);
    axiReq.bready <= 1'b0;
    check(got, 1'b1);
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    @(posedge ref_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= a;
    axiReq.rready  <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(negedge ref_clk);
      got = axiRsp.arready;
    end
    @(posedge ref_clk);
    axiReq.arvalid <= 1'b0;
    got = 1'b0;
    while (!got) begin
      @(negedge ref_clk);
      got = axiRsp.rvalid;
      d = axiRsp.rdata;
      r = axiRsp.rresp;
    end
    @(posedge ref_clk);
    axiReq.rready <= 1'b0;
    check(got, 1'b1);
  endtask : axi_read
  task automatic send(input logic [7:0] c);
    @(posedge ref_clk);
    rxChar <= '{valid: 1'b1, data: c};
    @(posedge ref_clk);
    rxChar.valid <= 1'b0;
    @(negedge ref_clk);
  endtask : send
  task automatic end_sim();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [1:0] r;
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      axi_read(ADRS[i], d, r);
      check(d, 32'h0);
      axi_write(ADRS[i], MASK[i], r);
      axi_read(ADRS[i], d, r);
      check({r, d}, {RESP_OKAY, MASK[i]});
      axi_write(ADRS[i], PROG[i], r);
      axi_read(ADRS[i], d, r);
      check(d, PROG[i]);
    end
    axi_read(8'h70, d, r);
    check({r, d}, {RESP_SLVERR, 32'h0});
    axi_write(8'h70, 32'h0, r);
    check(r, RESP_SLVERR);
  endtask : t_regs
  task automatic t_dma();
    logic [1:0] r;
    axi_write(ADDR_DMA_CTRL, 32'h0, r);
    @(posedge ref_clk);
    rxDataAvail  <= 1'b1;
    txSpaceAvail <= 1'b1;
    settle(3);
    check({rxDmaReq, txDmaReq}, 2'b00);
    axi_write(ADDR_DMA_CTRL, 32'h3, r);
    settle(3);
    check({rxDmaReq, txDmaReq}, 2'b11);
    @(posedge ref_clk);
    uartErrIrq <= 1'b1;
    settle(2);
    check(rxDmaReq, 1'b1);
    axi_write(ADDR_DMA_CTRL, 32'hB, r);
    settle(3);
    check({rxDmaReq, txDmaReq}, 2'b01);
    @(posedge ref_clk);
    uartErrIrq <= 1'b0;
    settle(2);
    check(rxDmaReq, 1'b1);
    axi_write(ADDR_DMA_CTRL, 32'h2, r);
  endtask : t_dma
  task automatic t_halt();
    logic [1:0] r;
    logic [31:0] d;
    for (int m = 0; m < 4; m++) begin
      axi_write(ADDR_FLOW_CFG, {27'h0, m[1:0], 3'h1}, r);
      send(8'h13);
      check(txHalt, m == 1 || m == 3);
      send(8'h11);
      check(txHalt, 1'b0);
      send(8'h93);
      check(txHalt, m >= 2);
      send(8'h91);
      check(txHalt, 1'b0);
    end
    axi_write(ADDR_FLOW_CFG, 32'h18, r);
    send(8'h13);
    check(txHalt, 1'b0);
    axi_write(ADDR_FLOW_CFG, 32'h29, r);
    send(8'h13);
    settle(1);
    check({txHalt, txDmaReq}, 2'b10);
    send(8'h41);
    check(txHalt, 1'b0);
    axi_write(ADDR_FLOW_CFG, 32'h09, r);
    send(8'h13);
    send(8'h41);
    check(txHalt, 1'b1);
    send(8'h11);
    check(txHalt, 1'b0);
    axi_write(ADDR_FLOW_CFG, 32'h49, r);
    send(8'h91);
    check(specialCharSeen, 1'b1);
    axi_read(ADDR_FLOW_STAT, d, r);
    check(d, 32'h2);
    axi_write(ADDR_FLOW_STAT, 32'h2, r);
    axi_read(ADDR_FLOW_STAT, d, r);
    check(d, 32'h0);
    axi_write(ADDR_FLOW_CFG, 32'h09, r);
    send(8'h91);
    check(specialCharSeen, 1'b0);
  endtask : t_halt
  task automatic t_insert();
    logic [1:0] r;
    for (int m = 1; m < 5; m++) begin
      @(posedge ref_clk);
      slow <= (m == 1) ? 4'h0 : 4'h5;
      axi_write(ADDR_FLOW_CFG, {29'h0, m[1:0], 1'b1}, r);
      @(posedge ref_clk);
      rxAlmostFull <= 1'b1;
      settle(30);
      check(sentLog, LOG_P[m % 4]);
      @(posedge ref_clk);
      rxAlmostFull <= 1'b0;
      settle(30);
      check(sentLog, LOG_R[m % 4]);
    end
  endtask : t_insert
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    axiReq = '0;
    rxChar = '0;
    {rxAlmostFull, rxDataAvail, txSpaceAvail, uartErrIrq} = 4'h0;
    slow = 4'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs();
    t_dma();
    t_halt();
    t_insert();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire

// ---- testbench/udsc_far_model.sv ----
/*
  udsc_far_model: transmitter side taking inserted flow chars, acking after
  slow cycles and logging the last two chars taken.
  assumes ref_clk domain, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module udsc_far_model (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire udsc_pkg::udsc_char_t txInsert,
  input  wire logic [3:0]           slow,
  output logic                      txInsertAck,
  output logic [15:0]               sentLog
);
  import udsc_pkg::*;
  logic [3:0] waitCnt_q;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      txInsertAck <= 1'b0;
      waitCnt_q   <= 4'h0;
      sentLog     <= 16'h0000;
    end else begin
      txInsertAck <= 1'b0;
      if (txInsert.valid && txInsertAck) begin
        sentLog   <= {sentLog[7:0], txInsert.data};
        waitCnt_q <= 4'h0;
      end else if (txInsert.valid && waitCnt_q >= slow) begin
        txInsertAck <= 1'b1;
      end else if (txInsert.valid) begin
        waitCnt_q <= waitCnt_q + 4'h1;
      end
    end
  end
endmodule : udsc_far_model
`default_nettype wire

// ---- testbench/udsc_top_monitor.sv ----
/*
  udsc_monitor: port-level checks of udsc_top.
  assumes one clock ref_clk and synchronous reset resetn.
*/
`timescale 1ns/1ps
`default_nettype none
module udsc_monitor (
  input wire logic                    ref_clk,
  input wire logic                    resetn,
  input wire udsc_pkg::udsc_axi_req_t axiReq,
  input wire udsc_pkg::udsc_axi_rsp_t axiRsp,
  input wire udsc_pkg::udsc_char_t    rxChar,
  input wire logic                    rxDataAvail,
  input wire logic                    txSpaceAvail,
  input wire logic                    txInsertAck,
  input wire udsc_pkg::udsc_char_t    txInsert,
  input wire logic                    txHalt,
  input wire logic                    specialCharSeen,
  input wire logic                    rxDmaReq,
  input wire logic                    txDmaReq
);
  import udsc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_rx_req_cause: assert property (rxDmaReq |-> $past(rxDataAvail))
    else $error("rx dma request without data");
  a_tx_req_cause: assert property (txDmaReq |-> $past(txSpaceAvail) && !$past(txHalt))
    else $error("tx dma request without room or while halted");
  a_halt_blocks_dma: assert property (txHalt |=> !txDmaReq)
    else $error("tx dma request while halted");
  a_halt_by_char: assert property ($rose(txHalt) |-> $past(rxChar.valid))
    else $error("halt rose with no received char");
  a_special_by_char: assert property (specialCharSeen |-> $past(rxChar.valid))
    else $error("special pulse with no received char");
  a_insert_holds: assert property (txInsert.valid && !txInsertAck |=>
    txInsert.valid && $stable(txInsert.data))
    else $error("inserted char dropped before ack");
  a_write_answer: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
    |-> ##2 axiRsp.bvalid)
    else $error("write response late");
  a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid && !axiRsp.arready)
    else $error("read response late");
  a_busy_ready: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write accepted while response pending");
  c_halt: cover property ($rose(txHalt));
  c_insert: cover property (txInsert.valid && txInsertAck);
  c_both_req: cover property (rxDmaReq && txDmaReq);
endmodule : udsc_monitor
bind udsc_top udsc_monitor mon_u (.ref_clk(ref_clk), .resetn(resetn), .axiReq(axiReq), .axiRsp(axiRsp),
  .rxChar(rxChar), .rxDataAvail(rxDataAvail), .txSpaceAvail(txSpaceAvail), .txInsertAck(txInsertAck),
  .txInsert(txInsert), .txHalt(txHalt), .specialCharSeen(specialCharSeen), .rxDmaReq(rxDmaReq),
  .txDmaReq(txDmaReq));
`default_nettype wire
